// file: rtl/scr_cmd_deser.sv
// deserialiser for the offset command link (start, data lsb first, stop)
`timescale 1ns/1ps
`default_nettype none
module scr_cmd_deser #(
    parameter int BIT_CYC = scr_pkg::CMD_BIT_CYC,
    parameter int W       = scr_pkg::CMD_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // synchronised line, idle high
    input  wire logic         rx_i,
    // received word
    output logic [W-1:0]      word_o,
    output logic              strobe_o
);
    typedef enum logic [1:0] {SCR_IDLE, SCR_START, SCR_DATA, SCR_STOP} scr_rx_t;
    scr_rx_t      state;
    logic [15:0]  cnt;
    logic [4:0]   nbit;
    logic [W-1:0] shreg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state    <= SCR_IDLE;
            cnt      <= 16'h0000;
            nbit     <= 5'h00;
            shreg    <= '0;
            word_o   <= '0;
            strobe_o <= 1'b0;
        end else begin
            strobe_o <= 1'b0;
            if (cnt != 16'h0000) begin
                cnt <= cnt - 16'h0001;
            end
            unique case (state)
                SCR_IDLE: begin
                    if (!rx_i) begin
                        state <= SCR_START;
                        cnt   <= 16'((BIT_CYC - 1) / 2);
                    end
                end
                SCR_START: begin
                    // a glitch shorter than half a bit is not a start
                    if (cnt == 16'h0000) begin
                        state <= rx_i ? SCR_IDLE : SCR_DATA;
                        cnt   <= 16'(BIT_CYC - 1);
                        nbit  <= 5'h00;
                    end
                end
                SCR_DATA: begin
                    if (cnt == 16'h0000) begin
                        shreg <= {rx_i, shreg[W-1:1]};
                        cnt   <= 16'(BIT_CYC - 1);
                        nbit  <= nbit + 5'h01;
                        if (nbit == 5'(W - 1)) begin
                            state <= SCR_STOP;
                        end
                    end
                end
                SCR_STOP: begin
                    // framing error: word dropped silently
                    if (cnt == 16'h0000) begin
                        state <= SCR_IDLE;
                        if (rx_i) begin
                            word_o   <= shreg;
                            strobe_o <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule : scr_cmd_deser
`default_nettype wire

// file: rtl/scr_pkg.sv
// shared constants of the segment channel control router
package scr_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NSEG       = 6;
    localparam int NADC       = 7;
    localparam int SPARE_IDX  = 6;
    localparam int TRIPLE_SZ  = 3;
    localparam int ADC_W      = 16;
    localparam int SAMPLE_W   = 14;
    localparam int OVL_BIT    = 14;
    localparam int SYNC_BIT   = 15;
    localparam int OFS_W      = 12;
    localparam int SEL_W      = 3;
    localparam int CMD_W      = 16;
    localparam int CMD_CH_LSB = 12;
    // ------------------------------------------------------------
    // register map, byte addresses on the wishbone port
    // ------------------------------------------------------------
    localparam int ADR_W = 5;
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_SPARE    = 5'h04;
    localparam logic [4:0] REG_STATUS   = 5'h08;
    localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
    localparam logic [4:0] REG_IRQ_MASK = 5'h10;
    localparam logic [4:0] REG_INSP     = 5'h14;
    localparam logic [4:0] REG_SYNC     = 5'h18;
    localparam logic [4:0] REG_LASTCMD  = 5'h1c;
    // ctrl fields
    localparam int CTRL_FRST_A = 0;
    localparam int CTRL_FRST_B = 1;
    localparam int CTRL_DAC_EN = 2;
    localparam int CTRL_OVL_EN = 3;
    localparam int CTRL_GATE   = 4;
    localparam int CTRL_W      = 5;
    localparam logic [4:0] CTRL_RST = 5'h10;
    // insp fields: dac a sel [2:0], dac b sel [6:4], logic 0 [9:8], logic 1 [11:10]
    localparam int INSP_DA_LSB = 0;
    localparam int INSP_DB_LSB = 4;
    localparam int INSP_L0_LSB = 8;
    localparam int INSP_L1_LSB = 10;
    // irq bits
    localparam int IRQ_INH_A = 0;
    localparam int IRQ_INH_B = 1;
    localparam int IRQ_OVL   = 2;
    localparam int IRQ_CMD   = 3;
    localparam int IRQ_SYNC  = 4;
    localparam int IRQ_W     = 5;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS   = 40;
    localparam int SLEW_NS  = 10000;
    localparam int SLEW_CYC = (SLEW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_LEN = 16;
    localparam int CMD_BIT_CYC = 4;
    localparam logic [15:0] SYNC_WORD = 16'hbc5c;
endpackage : scr_pkg

// file: rtl/scr_router.sv
// segment channel control and data routing for one segment card
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module scr_router #(
    parameter int SLEW_CYC    = scr_pkg::SLEW_CYC,
    parameter int SYNC_LEN    = scr_pkg::SYNC_LEN,
    parameter int CMD_BIT_CYC = scr_pkg::CMD_BIT_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             irq_o,
    // converters, index 6 is the spare
    input  wire logic [111:0] adc_word_i,
    // preamp cable
    input  wire logic        reset_busy_a_i,
    input  wire logic        reset_busy_b_i,
    output logic             fast_reset_off_triple_a_o,
    output logic             fast_reset_off_triple_b_o,
    output logic [1:0]       overload_reset_o,
    // input buffer routing to the spare converter
    output logic [5:0]       spare_buf_en_o,
    // serialiser words
    output logic [95:0]      link_word_o,
    output logic [5:0]       link_valid_o,
    // offset command link and offset dac values
    input  wire logic        offset_command_link_i,
    output logic [83:0]      offset_o,
    // inspection
    output logic [13:0]      insp_dac_a_o,
    output logic [13:0]      insp_dac_b_o,
    output logic             insp_dac_en_o,
    output logic [1:0]       insp_logic_o
);
    localparam int N          = scr_pkg::NSEG;
    localparam int AW         = scr_pkg::ADC_W;
    localparam int OW         = scr_pkg::OFS_W;
    localparam int SW         = scr_pkg::SAMPLE_W;
    localparam int CMD_CH_TOP = scr_pkg::CMD_CH_LSB + scr_pkg::SEL_W - 1;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic triple_of(input int k);
        triple_of = (k >= scr_pkg::TRIPLE_SZ);
    endfunction : triple_of

    function automatic logic [AW-1:0] adc_of(input logic [111:0] v, input logic [2:0] i);
        adc_of = v[AW*i +: AW];
    endfunction : adc_of

    // ------------------------------------------------------------
    // input synchronisers and command deserialiser
    // ------------------------------------------------------------
    wire logic [2:0] sync_lvl;
    wire logic       busy_a = sync_lvl[0];
    wire logic       busy_b = sync_lvl[1];
    wire logic       cmd_rx = ~sync_lvl[2];
    wire logic [scr_pkg::CMD_W-1:0] cmd_word;
    wire logic       cmd_stb;

    // the command line idles high; it crosses inverted so a reset stage never fakes a start
    scr_sync3 #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({~offset_command_link_i, reset_busy_b_i, reset_busy_a_i}),
        .level_o (sync_lvl)
    );

    scr_cmd_deser #(.BIT_CYC(CMD_BIT_CYC), .W(scr_pkg::CMD_W)) u_deser (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .rx_i     (cmd_rx),
        .word_o   (cmd_word),
        .strobe_o (cmd_stb)
    );

    // ------------------------------------------------------------
    // registers and bus decode
    // ------------------------------------------------------------
    logic [scr_pkg::CTRL_W-1:0] ctrl;
    logic [2:0]                 spare_sel;
    logic [11:0]                insp;
    logic [scr_pkg::IRQ_W-1:0]  irq_stat;
    logic [scr_pkg::IRQ_W-1:0]  irq_mask;
    logic [scr_pkg::CMD_W-1:0]  last_cmd;
    logic [15:0]                sync_cnt;
    logic                       busy_a_q;
    logic                       busy_b_q;

    wire logic req   = cyc_i && stb_i && !ack_o;
    wire logic wr    = req && we_i && sel_i[0];
    wire logic wr_lo = wr && sel_i[1];
    wire logic wr_ctrl  = wr && (adr_i == scr_pkg::REG_CTRL);
    wire logic wr_spare = wr && (adr_i == scr_pkg::REG_SPARE);
    wire logic wr_icl   = wr && (adr_i == scr_pkg::REG_IRQ_STAT);
    wire logic wr_imask = wr && (adr_i == scr_pkg::REG_IRQ_MASK);
    wire logic wr_insp  = wr_lo && (adr_i == scr_pkg::REG_INSP);
    wire logic wr_sync  = wr && (adr_i == scr_pkg::REG_SYNC) && dat_i[0];
    wire logic sync_act = (sync_cnt != 16'h0000);

    wire logic [31:0] rd_mux =
        (adr_i == scr_pkg::REG_CTRL)     ? 32'(ctrl) :
        (adr_i == scr_pkg::REG_SPARE)    ? 32'(spare_sel) :
        (adr_i == scr_pkg::REG_STATUS)   ? 32'({sync_act, busy_b, busy_a}) :
        (adr_i == scr_pkg::REG_IRQ_STAT) ? 32'(irq_stat) :
        (adr_i == scr_pkg::REG_IRQ_MASK) ? 32'(irq_mask) :
        (adr_i == scr_pkg::REG_INSP)     ? 32'(insp) :
        (adr_i == scr_pkg::REG_SYNC)     ? 32'(sync_act) :
        (adr_i == scr_pkg::REG_LASTCMD)  ? 32'(last_cmd) : 32'h0000_0000;

    // ------------------------------------------------------------
    // routing decode
    // ------------------------------------------------------------
    // only codes 1..6 route the spare; any other value means no substitute
    wire logic [2:0] next_spare = (dat_i[2:0] <= 3'(N)) ? dat_i[2:0] : 3'h0;
    wire logic [AW-1:0] spare_w = adc_of(adc_word_i, 3'(scr_pkg::SPARE_IDX));

    logic [AW-1:0] routed [N];
    logic [N-1:0]  chan_ovl;
    logic [N-1:0]  chan_busy;
    logic [OW-1:0] cur_ofs [N];
    logic [OW-1:0] tgt_ofs [N];
    logic [15:0]   slew_cnt;
    wire logic     slew_tick = (slew_cnt == 16'h0000);

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chan
            wire logic sub = (spare_sel == 3'(g + 1));
            // the spare word is placed on the replaced segment's link
            assign routed[g]    = sub ? spare_w : adc_of(adc_word_i, 3'(g));
            assign chan_ovl[g]  = routed[g][scr_pkg::OVL_BIT];
            assign chan_busy[g] = triple_of(g) ? busy_b : busy_a;

            wire logic hit = cmd_stb &&
                (cmd_word[CMD_CH_TOP:scr_pkg::CMD_CH_LSB] == 3'(g));

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    tgt_ofs[g] <= '0;
                    cur_ofs[g] <= '0;
                end else begin
                    if (hit) begin
                        tgt_ofs[g] <= cmd_word[OW-1:0];
                    end
                    // one lsb per slew period keeps the baseline filter undisturbed
                    if (slew_tick && cur_ofs[g] < tgt_ofs[g]) begin
                        cur_ofs[g] <= cur_ofs[g] + OW'(1);
                    end else if (slew_tick && cur_ofs[g] > tgt_ofs[g]) begin
                        cur_ofs[g] <= cur_ofs[g] - OW'(1);
                    end
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    link_word_o[AW*g +: AW] <= '0;
                    link_valid_o[g]         <= 1'b0;
                    spare_buf_en_o[g]       <= 1'b0;
                    offset_o[OW*g +: OW]    <= '0;
                end else begin
                    link_word_o[AW*g +: AW] <= sync_act ? scr_pkg::SYNC_WORD : routed[g];
                    link_valid_o[g]  <= sync_act || !(ctrl[scr_pkg::CTRL_GATE] && chan_busy[g]);
                    spare_buf_en_o[g]    <= sub;
                    offset_o[OW*g +: OW] <= cur_ofs[g];
                end
            end
        end
    endgenerate

    // the spare offset is taken from the segment it currently stands in for
    wire logic [OW-1:0] spare_ofs = (spare_sel != 3'h0) ? cur_ofs[spare_sel - 3'h1] : '0;
    wire logic [2:0] da_sel = insp[scr_pkg::INSP_DA_LSB +: 3];
    wire logic [2:0] db_sel = insp[scr_pkg::INSP_DB_LSB +: 3];
    wire logic [SW-1:0] da_val = (da_sel < 3'(N)) ? routed[da_sel][SW-1:0] : spare_w[SW-1:0];
    wire logic [SW-1:0] db_val = (db_sel < 3'(N)) ? routed[db_sel][SW-1:0] : spare_w[SW-1:0];
    wire logic [3:0] lsrc = {cmd_stb, sync_act, busy_b, busy_a};
    wire logic [1:0] l0_sel = insp[scr_pkg::INSP_L0_LSB +: 2];
    wire logic [1:0] l1_sel = insp[scr_pkg::INSP_L1_LSB +: 2];
    wire logic [scr_pkg::IRQ_W-1:0] events;
    assign events[scr_pkg::IRQ_INH_A] = busy_a && !busy_a_q;
    assign events[scr_pkg::IRQ_INH_B] = busy_b && !busy_b_q;
    assign events[scr_pkg::IRQ_OVL]   = |chan_ovl;
    assign events[scr_pkg::IRQ_CMD]   = cmd_stb;
    assign events[scr_pkg::IRQ_SYNC]  = (sync_cnt == 16'h0001);

    // ------------------------------------------------------------
    // bus registers and control
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o     <= 1'b0;
            dat_o     <= 32'h0000_0000;
            ctrl      <= scr_pkg::CTRL_RST;
            spare_sel <= 3'h0;
            insp      <= 12'h000;
            irq_mask  <= '0;
            last_cmd  <= '0;
            sync_cnt  <= 16'h0000;
        end else begin
            ack_o <= req;
            dat_o <= req ? rd_mux : 32'h0000_0000;
            if (wr_ctrl) begin
                ctrl <= dat_i[scr_pkg::CTRL_W-1:0];
            end
            // a single register holds the whole routing choice
            if (wr_spare) begin
                spare_sel <= next_spare;
            end
            if (wr_insp) begin
                insp <= dat_i[11:0];
            end
            if (wr_imask) begin
                irq_mask <= dat_i[scr_pkg::IRQ_W-1:0];
            end
            if (cmd_stb) begin
                last_cmd <= cmd_word;
            end
            if (wr_sync) begin
                sync_cnt <= 16'(SYNC_LEN);
            end else if (sync_act) begin
                sync_cnt <= sync_cnt - 16'h0001;
            end
        end
    end

    // events win over a simultaneous write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
            irq_o    <= 1'b0;
            busy_a_q <= 1'b0;
            busy_b_q <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_icl ? dat_i[scr_pkg::IRQ_W-1:0] : '0)) | events;
            irq_o    <= |(irq_stat & irq_mask);
            busy_a_q <= busy_a;
            busy_b_q <= busy_b;
        end
    end

    // ------------------------------------------------------------
    // pins to the preamps and inspection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_reset_off_triple_a_o <= 1'b0;
            fast_reset_off_triple_b_o <= 1'b0;
            overload_reset_o          <= 2'h0;
            offset_o[OW*scr_pkg::SPARE_IDX +: OW] <= '0;
            slew_cnt      <= 16'h0000;
            insp_dac_a_o  <= '0;
            insp_dac_b_o  <= '0;
            insp_dac_en_o <= 1'b0;
            insp_logic_o  <= 2'h0;
        end else begin
            fast_reset_off_triple_a_o <= ctrl[scr_pkg::CTRL_FRST_A];
            fast_reset_off_triple_b_o <= ctrl[scr_pkg::CTRL_FRST_B];
            overload_reset_o[0] <= ctrl[scr_pkg::CTRL_OVL_EN] && |chan_ovl[2:0];
            overload_reset_o[1] <= ctrl[scr_pkg::CTRL_OVL_EN] && |chan_ovl[5:3];
            offset_o[OW*scr_pkg::SPARE_IDX +: OW] <= spare_ofs;
            slew_cnt <= slew_tick ? 16'(SLEW_CYC - 1) : slew_cnt - 16'h0001;
            // a disabled dac is held at zero so it draws no activity
            insp_dac_en_o <= ctrl[scr_pkg::CTRL_DAC_EN];
            insp_dac_a_o  <= ctrl[scr_pkg::CTRL_DAC_EN] ? da_val : '0;
            insp_dac_b_o  <= ctrl[scr_pkg::CTRL_DAC_EN] ? db_val : '0;
            insp_logic_o  <= {lsrc[l1_sel], lsrc[l0_sel]};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_frst_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |-> ##2 fast_reset_off_triple_a_o == $past(dat_i[scr_pkg::CTRL_FRST_A], 2))
        else $error("fast reset disable a does not follow ctrl");
    chk_busy_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy_a && ctrl[scr_pkg::CTRL_GATE] && !sync_act) |=> !link_valid_o[0])
        else $error("channel 0 not suppressed during reset-busy");
    chk_spare_route: assert property (@(posedge clk_i) disable iff (rst_i)
        (spare_sel == 3'h3 && !sync_act) |=> link_word_o[47:32] == $past(spare_w))
        else $error("spare word not on replaced link");
    chk_buf_match: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot0(spare_buf_en_o) && (spare_buf_en_o[2] == $past(spare_sel == 3'h3)))
        else $error("buffer enable does not match spare selection");
    chk_spare_ofs: assert property (@(posedge clk_i) disable iff (rst_i)
        (spare_sel == 3'h3) |=> offset_o[83:72] == $past(cur_ofs[2]))
        else $error("spare offset not taken from its segment");
    chk_slew_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(slew_tick) |-> $stable(cur_ofs[0]))
        else $error("offset changed between slew ticks");
    chk_sync_len: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sync |-> ##2 (link_word_o[15:0] == scr_pkg::SYNC_WORD) [*8] ##1 sync_act)
        else $error("sync pattern too short");
    chk_busy_filter: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(reset_busy_a_i) ##1 reset_busy_a_i [*2] |-> !busy_a)
        else $error("reset-busy used before synchroniser settles");
    chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (|(irq_stat & irq_mask)) |=> irq_o)
        else $error("interrupt not raised for unmasked status");
    chk_frst_b_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |-> ##2 fast_reset_off_triple_b_o == $past(dat_i[scr_pkg::CTRL_FRST_B], 2))
        else $error("fast reset disable b does not follow ctrl");
    chk_busy_gate_b: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy_b && ctrl[scr_pkg::CTRL_GATE] && !sync_act) |=> !link_valid_o[3])
        else $error("channel 3 not suppressed during reset-busy");
    chk_ovl_fwd: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl[scr_pkg::CTRL_OVL_EN] && chan_ovl[4]) |=> overload_reset_o[1])
        else $error("overload not forwarded to triple b");
    chk_dac_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl[scr_pkg::CTRL_DAC_EN] |=>
            (insp_dac_a_o == '0 && insp_dac_b_o == '0 && !insp_dac_en_o))
        else $error("inspection dac active while disabled");
endmodule : scr_router
`default_nettype wire

// file: rtl/scr_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module scr_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] st1;
    logic [W-1:0] st2;
    logic [W-1:0] st3;

    // st1 is read only by st2; the level follows once st2 and st3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st1     <= '0;
            st2     <= '0;
            st3     <= '0;
            level_o <= '0;
        end else begin
            st1 <= async_i;
            st2 <= st1;
            st3 <= st2;
            for (int i = 0; i < W; i++) begin
                if (st2[i] == st3[i]) begin
                    level_o[i] <= st3[i];
                end
            end
        end
    end
endmodule : scr_sync3
`default_nettype wire

// file: sim/scr_preamp_model.sv
// far-side model: two triple preamps and the offset command sender
`timescale 1ns/1ps
`default_nettype none
module scr_preamp_model #(
    parameter int BIT_CYC = 4
) (
    // clock
    input  wire logic       clk_i,
    // cable lines
    input  wire logic       frst_off_a_i,
    input  wire logic       frst_off_b_i,
    output logic      [1:0] busy_o,
    // command line, idle high
    output logic            cmd_o
);
    initial begin
        busy_o = 2'b00;
        cmd_o  = 1'b1;
    end
    // a disabled fast reset never fires, so busy stays low
    task fast_reset(input bit t, input int n);
        if (!(t ? frst_off_b_i : frst_off_a_i)) begin
            busy_o[t] <= 1'b1;
            repeat (n) @(posedge clk_i);
            busy_o[t] <= 1'b0;
        end
    endtask : fast_reset
    task send(input logic [15:0] w);
        logic [17:0] f;
        f = {1'b1, w, 1'b0};
        for (int i = 0; i < 18; i++) begin
            cmd_o <= f[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
    endtask : send
endmodule : scr_preamp_model
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench of the segment channel router
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [4:0]   adr_i = '0;
    logic [3:0]   sel_i = 4'hf, wsel = 4'hf;
    logic [31:0]  dat_i = '0, dat_o, rd;
    logic         ack_o, irq_o, fa, fb, den, cmd;
    logic [111:0] adc;
    logic [1:0]   busy, ovl, il;
    logic [5:0]   ben, lv;
    logic [95:0]  lw;
    logic [83:0]  ofs;
    logic [13:0]  da, db;
    int           miscompares = 0, compares = 0;
    scr_router #(.SLEW_CYC(4), .SYNC_LEN(16), .CMD_BIT_CYC(4)) DUT (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .adc_word_i(adc), .reset_busy_a_i(busy[0]), .reset_busy_b_i(busy[1]),
        .fast_reset_off_triple_a_o(fa), .fast_reset_off_triple_b_o(fb),
        .overload_reset_o(ovl), .spare_buf_en_o(ben), .link_word_o(lw),
        .link_valid_o(lv), .offset_command_link_i(cmd), .offset_o(ofs),
        .insp_dac_a_o(da), .insp_dac_b_o(db), .insp_dac_en_o(den), .insp_logic_o(il));
    scr_preamp_model #(.BIT_CYC(4)) model (.clk_i(clk_i), .frst_off_a_i(fa),
        .frst_off_b_i(fb), .busy_o(busy), .cmd_o(cmd));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    // outputs are read right after the edge, before its updates land
    task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= wsel;
        adr_i <= a;
        dat_i <= d;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        `CHK("ack", 1'b1, ack_o)
    endtask : wb
    task t_ctrl;
        wb(0, scr_pkg::REG_CTRL, 0);
        `CHK("ctrl", 32'h10, rd)
        `CHK("frst_a", 1'b0, fa)
        wb(1, scr_pkg::REG_CTRL, 32'h17);
        wt(2);
        `CHK("frst_ab", 2'b11, {fb, fa})
        `CHK("dac_en", 1'b1, den)
        wb(1, scr_pkg::REG_CTRL, 32'h10);
        wb(0, 5'h02, 0);
        `CHK("unmapped", 32'h0, rd)
    endtask : t_ctrl
    task t_spare;
        wb(1, scr_pkg::REG_SPARE, 3);
        wt(3);
        `CHK("buf_en", 6'h04, ben)
        `CHK("link2", 16'h0166, lw[32+:16])
        `CHK("link0", 16'h0100, lw[0+:16])
        wb(1, scr_pkg::REG_SPARE, 7);
        wb(0, scr_pkg::REG_SPARE, 0);
        `CHK("spare7", 32'h0, rd)
        wt(3);
        `CHK("buf_off", 6'h00, ben)
        wb(1, scr_pkg::REG_SPARE, 3);
    endtask : t_spare
    task t_busy;
        wb(1, scr_pkg::REG_IRQ_MASK, 1);
        fork
            model.fast_reset(0, 12);
            begin
                wt(7);
                `CHK("valid_inh", 6'h38, lv)
                `CHK("irq_on", 1'b1, irq_o)
            end
        join
        wt(8);
        `CHK("valid_end", 6'h3f, lv)
        wb(0, scr_pkg::REG_IRQ_STAT, 0);
        `CHK("irq_stat", 1'b1, rd[0])
        wb(1, scr_pkg::REG_IRQ_STAT, 1);
        wt(2);
        `CHK("irq_off", 1'b0, irq_o)
        wb(1, scr_pkg::REG_CTRL, 32'h11);
        wt(2);
        model.fast_reset(0, 12);
        wt(7);
        `CHK("valid_off", 6'h3f, lv)
        fork
            model.fast_reset(1, 12);
            begin
                wt(7);
                `CHK("valid_b", 6'h07, lv)
            end
        join
        wt(8);
        `CHK("valid_b_end", 6'h3f, lv)
    endtask : t_busy
    task t_cmd;
        model.send(16'h2005);
        wt(8);
        `CHK("slow", 1'b0, ofs[24+:12] == 12'h005)
        wt(40);
        `CHK("ofs2", 12'h005, ofs[24+:12])
        `CHK("ofs_spare", 12'h005, ofs[72+:12])
        wb(0, scr_pkg::REG_LASTCMD, 0);
        `CHK("lastcmd", 32'h2005, rd)
    endtask : t_cmd
    task t_insp;
        wsel = 4'h1;
        wb(1, scr_pkg::REG_INSP, 32'h0fff);
        wsel = 4'hf;
        wb(0, scr_pkg::REG_INSP, 0);
        `CHK("insp_sel", 32'h0, rd)
        wb(1, scr_pkg::REG_INSP, 32'h0861);
        wb(1, scr_pkg::REG_CTRL, 32'h1d);
        adc[16*4+14] <= 1'b1;
        wt(3);
        `CHK("dac_a", 14'h0111, da)
        `CHK("dac_b", 14'h0166, db)
        `CHK("ovl_rst", 2'b10, ovl)
        wb(1, scr_pkg::REG_SYNC, 1);
        wt(2);
        `CHK("insp_logic", 2'b10, il)
        adc[16*4+14] <= 1'b0;
        wb(1, scr_pkg::REG_CTRL, 32'h11);
        wt(2);
        `CHK("dac_off", 14'h0, da)
        `CHK("dac_en_off", 1'b0, den)
    endtask : t_insp
    task t_sync;
        wb(1, scr_pkg::REG_SYNC, 1);
        wt(2);
        `CHK("sync", {6{16'hbc5c}}, lw)
        wt(20);
        `CHK("sync_end", 16'h0100, lw[0+:16])
    endtask : t_sync
    task results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        for (int k = 0; k < 7; k++) begin
            adc[16*k+:16] <= 16'(16'h0100 + 16'h0011 * k);
        end
        wt(5);
        rst_i <= 1'b0;
        wt(4);
        t_ctrl();
        t_spare();
        t_busy();
        t_cmd();
        t_insp();
        t_sync();
        results();
    end
    initial begin
        wt(5000);
        miscompares++;
        results();
    end
endmodule : tb_top
`default_nettype wire
